/* rtl/spfc_pkg.sv */
/*
 * Shared constants, carriers and enumerations of the self-program flash control block.
 * Assumes a 20 MHz core clock and a core that drives one-cycle strobes.
 */
package spfc_pkg;

	////////////////////////////////////////////////////////////////////////////
	// register placement and fields
	localparam logic [15:0] SPFC_CSR_DATA_ADDR = 16'h0057;
	localparam logic [15:0] SPFC_IO_SHIFT = 16'h0020;
	localparam logic [15:0] SPFC_CSR_IO_ADDR = SPFC_CSR_DATA_ADDR - SPFC_IO_SHIFT;
	localparam int SPFC_BIT_IRQEN = 7;
	localparam int SPFC_BIT_BUSY = 6;
	localparam int SPFC_BIT_EN = 0;
	localparam logic [7:0] SPFC_CSR_RESET = 8'h00;
	localparam logic [7:0] SPFC_LOCK_RESET = 8'hFF;
	localparam logic [5:0] SPFC_CMD_NONE = 6'h00;
	localparam logic [5:0] SPFC_CMD_FILL = 6'h01;
	localparam logic [5:0] SPFC_CMD_PGER = 6'h03;
	localparam logic [5:0] SPFC_CMD_PGWR = 6'h05;
	localparam logic [5:0] SPFC_CMD_LOCK = 6'h09;
	localparam logic [5:0] SPFC_CMD_REEN = 6'h11;
	localparam logic [5:0] SPFC_CMD_SIG = 6'h21;

	////////////////////////////////////////////////////////////////////////////
	// windows, addressing and timing
	localparam logic [2:0] SPFC_SPM_WINDOW = 3'h4;
	localparam logic [2:0] SPFC_LPM_WINDOW = 3'h3;
	localparam int SPFC_PAGE_WORDS = 32;
	localparam int SPFC_Z_PAGE_MSB = 12;
	localparam int SPFC_Z_PAGE_LSB = 6;
	localparam int SPFC_Z_WORD_MSB = 5;
	localparam int SPFC_Z_WORD_LSB = 1;
	localparam int SPFC_Z_ADDR_MSB = 14;
	localparam logic [13:0] SPFC_STALL_BASE = 14'h3800;
	localparam logic [15:0] SPFC_ERASED_WORD = 16'hFFFF;
	localparam int SPFC_CLK_KHZ = 20000;
	localparam int SPFC_PROG_MIN_US = 3200;
	localparam int SPFC_PROG_MAX_US = 3400;
	localparam int SPFC_PROG_MIN_CYC = (SPFC_PROG_MIN_US * SPFC_CLK_KHZ + 999) / 1000;
	localparam int SPFC_PROG_MAX_CYC = (SPFC_PROG_MAX_US * SPFC_CLK_KHZ) / 1000;
	localparam logic [16:0] SPFC_PROG_CYCLES = 17'(SPFC_PROG_MIN_CYC);

	////////////////////////////////////////////////////////////////////////////
	// carriers and enumerations
	typedef struct packed {
		logic wr;
		logic rd;
		logic io;
		logic [15:0] addr;
		logic [7:0] wdata;
	} spfc_reg_req_t;

	typedef struct packed {
		logic valid;
		logic [15:0] data;
		logic [15:0] z;
	} spfc_spm_req_t;

	typedef struct packed {
		logic valid;
		logic [15:0] z;
	} spfc_lpm_req_t;

	typedef enum logic [1:0] {ST_IDLE, ST_ARMED, ST_BUSY} spfc_state_t;
	typedef enum logic [2:0] {CMD_FILL, CMD_ERASE, CMD_WRITE, CMD_LOCK, CMD_REEN, CMD_SIG} spfc_cmd_t;

endpackage : spfc_pkg

/* rtl/spfc_prog_timer.sv */
/*
 * Flash operation timer: holds busy for a fixed count of core clocks after start.
 * Assumes start is a one-cycle pulse and is ignored while busy.
 */
`timescale 1ns/1ps
module spfc_prog_timer
	import spfc_pkg::*;
#(
	parameter logic [16:0] CYCLES = SPFC_PROG_CYCLES
)
(
	input wire logic clock,
	input wire logic rst,
	input wire logic start,
	output logic busy,
	output logic done
);

	logic [16:0] count;
	logic [16:0] lenCount;

	always_ff @(posedge clock)
	begin
		if (rst)
		begin
			count <= 17'h00000;
			busy <= 1'b0;
			done <= 1'b0;
		end
		else
		begin
			done <= 1'b0;
			if (start && !busy)
			begin
				count <= CYCLES - 17'h00001;
				busy <= 1'b1;
			end
			else if (busy)
			begin
				if (count == 17'h00000)
				begin
					busy <= 1'b0;
					done <= 1'b1;
				end
				else
					count <= count - 17'h00001;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// checks
	always_ff @(posedge clock)
	begin
		if (rst || (start && !busy))
			lenCount <= 17'h00000;
		else if (busy)
			lenCount <= lenCount + 17'h00001;
	end

	property p_prog_length;
		@(posedge clock) disable iff (rst)
		done |-> (lenCount == CYCLES);
	endproperty
	a_prog_length: assert property (p_prog_length) else $error("busy time differs from programmed count");

endmodule : spfc_prog_timer

/* rtl/spfc_flash_control.sv */
/*
 * Self-program flash control: control/status register, timed store and load windows,
 * temporary page buffer, page erase/write sequencing, lock byte and lock modes.
 * Assumes the core presents one-cycle register, store and load strobes on this clock.
 */
`timescale 1ns/1ps
module spfc_flash_control
	import spfc_pkg::*;
#(
	parameter logic [16:0] PROG_CYCLES = SPFC_PROG_CYCLES
)
(
	input wire logic clock,
	input wire logic rst,
	input spfc_reg_req_t regReq,
	output logic [7:0] regRdata,
	input spfc_spm_req_t spmReq,
	input spfc_lpm_req_t lpmReq,
	input wire logic globalIrqEnable,
	input wire logic [7:0] fuseByte,
	input wire logic [7:0] signatureByte,
	input wire logic chipErase,
	input wire logic [4:0] bufRdIndex,
	output logic [15:0] bufRdData,
	output logic [7:0] lpmData,
	output logic lpmValid,
	output logic irqReq,
	output logic regionBlocked,
	output logic cpuHalt,
	output logic flashErase,
	output logic flashWrite,
	output logic [6:0] flashPage,
	output logic [7:0] lockByte,
	output logic progLocked,
	output logic verifyLocked,
	output logic fuseLocked,
	output logic bootLockLocked
);

	////////////////////////////////////////////////////////////////////////////
	// decode helpers
	function automatic logic csrHit(input spfc_reg_req_t r);
		if (r.io)
			csrHit = (r.addr == SPFC_CSR_IO_ADDR);
		else
			csrHit = (r.addr == SPFC_CSR_DATA_ADDR);
	endfunction : csrHit

	function automatic logic cmdLegal(input logic [5:0] c);
		cmdLegal = (c == SPFC_CMD_FILL) || (c == SPFC_CMD_PGER) || (c == SPFC_CMD_PGWR) ||
			(c == SPFC_CMD_LOCK) || (c == SPFC_CMD_REEN) || (c == SPFC_CMD_SIG);
	endfunction : cmdLegal

	function automatic spfc_cmd_t decodeCmd(input logic [5:0] c);
		if (c == SPFC_CMD_PGER)
			decodeCmd = CMD_ERASE;
		else if (c == SPFC_CMD_PGWR)
			decodeCmd = CMD_WRITE;
		else if (c == SPFC_CMD_LOCK)
			decodeCmd = CMD_LOCK;
		else if (c == SPFC_CMD_REEN)
			decodeCmd = CMD_REEN;
		else if (c == SPFC_CMD_SIG)
			decodeCmd = CMD_SIG;
		else
			decodeCmd = CMD_FILL;
	endfunction : decodeCmd

	function automatic logic [5:0] cmdField(input spfc_cmd_t c);
		case (c)
			CMD_ERASE: cmdField = SPFC_CMD_PGER;
			CMD_WRITE: cmdField = SPFC_CMD_PGWR;
			CMD_LOCK: cmdField = SPFC_CMD_LOCK;
			CMD_REEN: cmdField = SPFC_CMD_REEN;
			CMD_SIG: cmdField = SPFC_CMD_SIG;
			default: cmdField = SPFC_CMD_FILL;
		endcase
	endfunction : cmdField

	////////////////////////////////////////////////////////////////////////////
	// declarations
	spfc_state_t state;
	spfc_cmd_t cmd;
	spfc_cmd_t next_cmd;
	logic irqEnable;
	logic [2:0] armCount;
	logic [2:0] lpmCount;
	logic [7:0] csrView;
	logic csrWr;
	logic cmdAccept;
	logic spmHit;
	logic lpmHit;
	logic fillHit;
	logic opStart;
	logic regionOp;
	logic stallTarget;
	logic discard;
	logic bufLoaded;
	logic opBusy;
	logic opDone;
	logic [5:0] lockData;
	logic [13:0] wordAddr;
	logic [15:0] pageBuf [SPFC_PAGE_WORDS];

	assign csrWr = regReq.wr && csrHit(regReq);
	assign next_cmd = decodeCmd(regReq.wdata[5:0]);
	assign cmdAccept = csrWr && (state == ST_IDLE) && cmdLegal(regReq.wdata[5:0]);
	assign spmHit = spmReq.valid && (state == ST_ARMED);
	assign lpmHit = lpmReq.valid && (state == ST_ARMED) && (lpmCount != 3'h0) &&
		((cmd == CMD_SIG) || (cmd == CMD_LOCK));
	assign fillHit = spmHit && (cmd == CMD_FILL);
	assign opStart = spmHit && ((cmd == CMD_ERASE) || (cmd == CMD_WRITE) || (cmd == CMD_LOCK));
	assign regionOp = (cmd == CMD_ERASE) || (cmd == CMD_WRITE);
	assign wordAddr = spmReq.z[SPFC_Z_ADDR_MSB:SPFC_Z_WORD_LSB];
	assign stallTarget = (wordAddr >= SPFC_STALL_BASE);
	assign discard = cmdAccept && (next_cmd == CMD_REEN) && bufLoaded;

	always_comb
	begin
		csrView = {irqEnable, regionBlocked, (state == ST_IDLE) ? SPFC_CMD_NONE : cmdField(cmd)};
	end

	////////////////////////////////////////////////////////////////////////////
	// command sequencer
	always_ff @(posedge clock)
	begin
		if (rst)
		begin
			state <= ST_IDLE;
			cmd <= CMD_FILL;
			armCount <= 3'h0;
			lpmCount <= 3'h0;
		end
		else
		begin
			case (state)
				ST_IDLE:
				begin
					if (cmdAccept)
					begin
						state <= ST_ARMED;
						cmd <= next_cmd;
						armCount <= SPFC_SPM_WINDOW;
						lpmCount <= SPFC_LPM_WINDOW;
					end
				end
				ST_ARMED:
				begin
					armCount <= armCount - 3'h1;
					if (lpmCount != 3'h0)
						lpmCount <= lpmCount - 3'h1;
					if (opStart)
						state <= ST_BUSY;
					else if (spmHit && (cmd != CMD_SIG))
						state <= ST_IDLE;
					else if (lpmHit)
						state <= ST_IDLE;
					else if (armCount == 3'h1)
						state <= ST_IDLE;
				end
				ST_BUSY:
				begin
					if (opDone)
						state <= ST_IDLE;
				end
				default:
					state <= ST_IDLE;
			endcase
		end
	end

	spfc_prog_timer #(
		.CYCLES(PROG_CYCLES)
	) uTimer (
		.clock(clock),
		.rst(rst),
		.start(opStart),
		.busy(opBusy),
		.done(opDone)
	);

	////////////////////////////////////////////////////////////////////////////
	// control/status register
	always_ff @(posedge clock)
	begin
		if (rst)
			irqEnable <= SPFC_CSR_RESET[SPFC_BIT_IRQEN];
		else if (csrWr)
			irqEnable <= regReq.wdata[SPFC_BIT_IRQEN];
	end

	always_ff @(posedge clock)
	begin
		if (rst)
			regRdata <= SPFC_CSR_RESET;
		else if (regReq.rd && csrHit(regReq))
			regRdata <= csrView;
		else
			regRdata <= 8'h00;
	end

	// set wins over clear, though both cannot come from one store
	always_ff @(posedge clock)
	begin
		if (rst)
			regionBlocked <= SPFC_CSR_RESET[SPFC_BIT_BUSY];
		else if (opStart && regionOp && !stallTarget)
			regionBlocked <= 1'b1;
		else if (fillHit)
			regionBlocked <= 1'b0;
		else if (spmHit && (cmd == CMD_REEN))
			regionBlocked <= 1'b0;
	end

	always_ff @(posedge clock)
	begin
		if (rst)
			irqReq <= 1'b0;
		else
			irqReq <= irqEnable && globalIrqEnable && !csrView[SPFC_BIT_EN];
	end

	////////////////////////////////////////////////////////////////////////////
	// flash operation outputs
	always_ff @(posedge clock)
	begin
		if (rst)
		begin
			flashErase <= 1'b0;
			flashWrite <= 1'b0;
			flashPage <= 7'h00;
		end
		else
		begin
			flashErase <= opStart && (cmd == CMD_ERASE);
			flashWrite <= opStart && (cmd == CMD_WRITE);
			if (opStart && regionOp)
				flashPage <= spmReq.z[SPFC_Z_PAGE_MSB:SPFC_Z_PAGE_LSB];
		end
	end

	always_ff @(posedge clock)
	begin
		if (rst)
			cpuHalt <= 1'b0;
		else if (opStart && regionOp && stallTarget)
			cpuHalt <= 1'b1;
		else if (opDone)
			cpuHalt <= 1'b0;
	end

	////////////////////////////////////////////////////////////////////////////
	// temporary page buffer
	genvar g;
	generate
		for (g = 0; g < SPFC_PAGE_WORDS; g++)
		begin : gBuf
			always_ff @(posedge clock)
			begin
				if (rst || discard)
					pageBuf[g] <= SPFC_ERASED_WORD;
				else if (fillHit && (spmReq.z[SPFC_Z_WORD_MSB:SPFC_Z_WORD_LSB] == 5'(g)))
					pageBuf[g] <= spmReq.data;
			end
		end
	endgenerate

	always_ff @(posedge clock)
	begin
		if (rst)
			bufLoaded <= 1'b0;
		else if (fillHit)
			bufLoaded <= 1'b1;
		else if (discard || (opStart && (cmd == CMD_WRITE)))
			bufLoaded <= 1'b0;
	end

	always_ff @(posedge clock)
	begin
		if (rst)
			bufRdData <= SPFC_ERASED_WORD;
		else
			bufRdData <= pageBuf[bufRdIndex];
	end

	////////////////////////////////////////////////////////////////////////////
	// lock byte and protection modes
	always_ff @(posedge clock)
	begin
		if (rst)
			lockData <= 6'h3F;
		else if (opStart && (cmd == CMD_LOCK))
			lockData <= spmReq.data[5:0];
	end

	always_ff @(posedge clock)
	begin
		if (rst || chipErase)
			lockByte <= SPFC_LOCK_RESET;
		else if (opDone && (cmd == CMD_LOCK))
			lockByte <= lockByte & {2'b11, lockData};
	end

	always_ff @(posedge clock)
	begin
		if (rst)
		begin
			progLocked <= 1'b0;
			fuseLocked <= 1'b0;
			verifyLocked <= 1'b0;
			bootLockLocked <= 1'b0;
		end
		else
		begin
			progLocked <= !(lockByte[1] && lockByte[0]);
			fuseLocked <= !(lockByte[1] && lockByte[0]);
			verifyLocked <= !lockByte[1] && !lockByte[0];
			bootLockLocked <= !lockByte[1] && !lockByte[0];
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// special loads
	always_ff @(posedge clock)
	begin
		if (rst)
		begin
			lpmData <= 8'h00;
			lpmValid <= 1'b0;
		end
		else
		begin
			lpmValid <= lpmHit;
			if (lpmHit && (cmd == CMD_SIG))
				lpmData <= signatureByte;
			else if (lpmHit)
				lpmData <= lpmReq.z[0] ? fuseByte : lockByte;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// checks
	property p_irq;
		@(posedge clock) disable iff (rst)
		(irqEnable && globalIrqEnable && !csrView[SPFC_BIT_EN]) |=> irqReq;
	endproperty
	a_irq: assert property (p_irq) else $error("ready request missing");

	property p_busy_set;
		@(posedge clock) disable iff (rst)
		(opStart && regionOp && !stallTarget) |=> regionBlocked && csrView[SPFC_BIT_BUSY];
	endproperty
	a_busy_set: assert property (p_busy_set) else $error("region busy not set");

	property p_fill_clear;
		@(posedge clock) disable iff (rst)
		fillHit |=> !regionBlocked;
	endproperty
	a_fill_clear: assert property (p_fill_clear) else $error("fill left region busy");

	property p_window;
		@(posedge clock) disable iff (rst)
		cmdAccept |=> ##[0:4] (state != ST_ARMED);
	endproperty
	a_window: assert property (p_window) else $error("store window longer than four cycles");

	property p_busy_en;
		@(posedge clock) disable iff (rst)
		opBusy |-> csrView[SPFC_BIT_EN];
	endproperty
	a_busy_en: assert property (p_busy_en) else $error("enable dropped while flash busy");

	property p_halt;
		@(posedge clock) disable iff (rst)
		(opStart && regionOp && stallTarget) |=> cpuHalt [*2];
	endproperty
	a_halt: assert property (p_halt) else $error("core not halted");

	property p_sig;
		@(posedge clock) disable iff (rst)
		(lpmHit && (cmd == CMD_SIG)) |=> lpmValid && (lpmData == $past(signatureByte));
	endproperty
	a_sig: assert property (p_sig) else $error("signature byte not returned");

	property p_lock_mono;
		@(posedge clock) disable iff (rst)
		!chipErase |=> ((lockByte & ~$past(lockByte)) == 8'h00);
	endproperty
	a_lock_mono: assert property (p_lock_mono) else $error("lock bit returned to one");

	property p_mode3;
		@(posedge clock) disable iff (rst)
		(lockByte[1:0] == 2'b00) |=> verifyLocked && bootLockLocked && progLocked;
	endproperty
	a_mode3: assert property (p_mode3) else $error("lock mode three not applied");

	property p_discard;
		@(posedge clock) disable iff (rst)
		discard |=> !bufLoaded && (csrView[5:0] == SPFC_CMD_REEN);
	endproperty
	a_discard: assert property (p_discard) else $error("buffer not discarded");

	c_fill: cover property (@(posedge clock) disable iff (rst) fillHit);
	c_erase: cover property (@(posedge clock) disable iff (rst) opStart && (cmd == CMD_ERASE) ##1 regionBlocked);
	c_lock_read: cover property (@(posedge clock) disable iff (rst) lpmHit && (cmd == CMD_LOCK));

endmodule : spfc_flash_control

/* dv/spfc_core_model.sv */
/*
 * Core model: issues register accesses and one-cycle store and load strobes.
 * Assumes tasks are entered just after a rising clock edge.
 */
`timescale 1ns/1ps
module spfc_core_model
	import spfc_pkg::*;
(
	input wire logic clock,
	output spfc_reg_req_t regReq,
	output spfc_spm_req_t spmReq,
	output spfc_lpm_req_t lpmReq,
	output logic rdDone
);
	initial
	begin
		regReq = '0;
		spmReq = '0;
		lpmReq = '0;
	end

	// marks the cycle in which read data is due
	always @(posedge clock)
		rdDone <= regReq.rd;

	////////////////////////////////////////////////////////////////////////////
	// released strobes drop to zero; the other released fields show inverted values
	task automatic csr(input logic w, input logic io, input logic [15:0] a, input logic [7:0] d);
		@(posedge clock);
		regReq <= '{wr: w, rd: !w, io: io, addr: a, wdata: d};
		@(posedge clock);
		regReq <= '{wr: 1'b0, rd: 1'b0, io: !io, addr: ~a, wdata: ~d};
	endtask : csr

	// gap models a slow core
	task automatic spm(input int gap, input logic [15:0] d, input logic [15:0] z);
		repeat (gap) @(posedge clock);
		@(posedge clock);
		spmReq <= '{valid: 1'b1, data: d, z: z};
		@(posedge clock);
		spmReq <= '{valid: 1'b0, data: ~d, z: ~z};
	endtask : spm

	task automatic lpm(input logic [15:0] z);
		@(posedge clock);
		lpmReq <= '{valid: 1'b1, z: z};
		@(posedge clock);
		lpmReq <= '{valid: 1'b0, z: ~z};
	endtask : lpm
endmodule : spfc_core_model

/* dv/spfc_flash_control_tb_top.sv */
/*
 * Self-checking bench of the flash control block.
 * Assumes the core model drives all register, store and load strobes; short program time.
 */
`timescale 1ns/1ps
module spfc_flash_control_tb_top
	import spfc_pkg::*;
;
	localparam logic [16:0] PCYC = 17'h00010;
	logic clock = 1'b0;
	logic rst = 1'b1;
	logic globalIrqEnable = 1'b0;
	logic [7:0] fuseByte = 8'h00;
	logic [7:0] signatureByte = 8'h00;
	logic chipErase = 1'b0;
	logic [4:0] bufRdIndex = 5'h00;
	spfc_reg_req_t regReq;
	spfc_spm_req_t spmReq;
	spfc_lpm_req_t lpmReq;
	logic rdDone, lpmValid, irqReq, regionBlocked, cpuHalt, flashErase, flashWrite;
	logic progLocked, verifyLocked, fuseLocked, bootLockLocked;
	logic [7:0] regRdata, lpmData, lockByte;
	logic [15:0] bufRdData;
	logic [6:0] flashPage;
	logic [7:0] expQ[$];
	int errCount = 0;
	int numChecks = 0;
	int nErase = 0;
	int nWrite = 0;
	logic [15:0] w;
	logic [4:0] idx;
	logic [6:0] pg;
	logic [7:0] bad[4] = '{8'h07, 8'h0B, 8'h13, 8'h02};
	logic [7:0] lockR0[2] = '{8'hFE, 8'h00};
	logic [7:0] lockExp[2] = '{8'hFE, 8'hC0};
	logic [3:0] modeExp[2] = '{4'hC, 4'hF};
	int n;

	always #25 clock = ~clock;

	spfc_core_model core (.clock(clock), .regReq(regReq), .spmReq(spmReq), .lpmReq(lpmReq), .rdDone(rdDone));

	spfc_flash_control #(.PROG_CYCLES(PCYC)) dut (
		.clock(clock), .rst(rst), .regReq(regReq), .regRdata(regRdata), .spmReq(spmReq), .lpmReq(lpmReq),
		.globalIrqEnable(globalIrqEnable), .fuseByte(fuseByte), .signatureByte(signatureByte),
		.chipErase(chipErase), .bufRdIndex(bufRdIndex), .bufRdData(bufRdData), .lpmData(lpmData),
		.lpmValid(lpmValid), .irqReq(irqReq), .regionBlocked(regionBlocked), .cpuHalt(cpuHalt),
		.flashErase(flashErase), .flashWrite(flashWrite), .flashPage(flashPage), .lockByte(lockByte),
		.progLocked(progLocked), .verifyLocked(verifyLocked), .fuseLocked(fuseLocked),
		.bootLockLocked(bootLockLocked)
	);

	////////////////////////////////////////////////////////////////////////////
	// shared tasks
	task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string m);
		numChecks++;
		if (got !== exp)
		begin
			errCount++;
			$display("mismatch at %0t: %s got %h expected %h", $time, m, got, exp);
		end
	endtask : chk

	task automatic complete_run;
		$display("checks %0d mismatches %0d", numChecks, errCount);
		if (errCount == 0 && numChecks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : complete_run

	task automatic cyc(input int k);
		repeat (k) @(posedge clock);
		#1;
	endtask : cyc

	task automatic rd(input logic io, input logic [15:0] a, input logic [7:0] e);
		expQ.push_back(e);
		core.csr(1'b0, io, a, 8'h00);
		@(posedge clock);
	endtask : rd

	task automatic wr(input logic [7:0] d);
		core.csr(1'b1, 1'b0, SPFC_CSR_DATA_ADDR, d);
	endtask : wr

	task automatic lp(input logic [15:0] z, input logic [7:0] e);
		expQ.push_back(e);
		core.lpm(z);
		@(posedge clock);
	endtask : lp

	////////////////////////////////////////////////////////////////////////////
	// answer monitor
	always @(posedge clock)
	begin
		if (rdDone === 1'b1 || lpmValid === 1'b1)
		begin
			if (expQ.size() == 0)
				chk({8'h00, regRdata}, 16'hFFFF, "unexpected answer");
			else
				chk(lpmValid === 1'b1 ? {8'h00, lpmData} : {8'h00, regRdata}, {8'h00, expQ.pop_front()}, "answer");
		end
		if (flashErase === 1'b1)
			nErase++;
		if (flashWrite === 1'b1)
			nWrite++;
	end

	initial
	begin
		#(50 * 20000);
		$display("mismatch at %0t: run timed out", $time);
		errCount++;
		complete_run();
	end

	////////////////////////////////////////////////////////////////////////////
	// scenarios
	initial
	begin
		void'($urandom(32'h3B8F88D4));
		repeat (6) @(posedge clock);
		rst <= 1'b0;
		fuseByte <= 8'($urandom);
		signatureByte <= 8'($urandom);
		rd(1'b0, SPFC_CSR_DATA_ADDR, 8'h00);
		rd(1'b1, SPFC_CSR_IO_ADDR, 8'h00);
		rd(1'b0, 16'h0058, 8'h00);
		chk({8'h00, lockByte}, 16'h00FF, "lock reset");
		chk(bufRdData, SPFC_ERASED_WORD, "buffer reset");
		$display("test reset done");

		w = 16'($urandom);
		idx = 5'($urandom);
		bufRdIndex <= idx;
		wr(8'h01);
		core.spm(2, w, {10'h000, idx, 1'b1});
		cyc(2);
		chk(bufRdData, w, "fill word");
		rd(1'b0, SPFC_CSR_DATA_ADDR, 8'h00);
		wr(8'h05);
		core.spm(3, 16'h0000, 16'h0000);
		cyc(2);
		chk(16'(nWrite), 16'h0000, "late store");
		foreach (bad[i])
		begin
			wr(bad[i]);
			core.spm(0, 16'h0000, 16'h0040);
			rd(1'b0, SPFC_CSR_DATA_ADDR, 8'h00);
		end
		chk(16'(nErase + nWrite), 16'h0000, "bad combination");
		$display("test fill done");

		pg = 7'($urandom);
		wr(8'h03);
		core.spm(0, 16'h0000, {3'b000, pg, 6'h00});
		cyc(2);
		chk(16'(nErase), 16'h0001, "erase");
		chk({9'h000, flashPage}, {9'h000, pg}, "erase page");
		chk({14'h0000, regionBlocked, cpuHalt}, 16'h0002, "region busy");
		rd(1'b0, SPFC_CSR_DATA_ADDR, 8'h43);
		wr(8'h11);
		core.spm(0, 16'h0000, 16'h0000);
		cyc(1);
		chk({15'h0000, regionBlocked}, 16'h0001, "reopen while busy");
		cyc(PCYC + 4);
		rd(1'b0, SPFC_CSR_DATA_ADDR, 8'h40);
		wr(8'h01);
		core.spm(0, ~w, {10'h000, idx, 1'b0});
		cyc(2);
		chk({15'h0000, regionBlocked}, 16'h0000, "fill clears busy");
		wr(8'h11);
		core.spm(0, 16'h0000, 16'h0000);
		cyc(2);
		chk(bufRdData, SPFC_ERASED_WORD, "discard");
		wr(8'h01);
		core.spm(0, w, {10'h000, idx, 1'b0});
		wr(8'h05);
		core.spm(0, 16'h0000, {3'b000, ~pg, 6'h00});
		cyc(2);
		chk({8'(nWrite), 1'b0, flashPage}, {8'h01, 1'b0, ~pg}, "page write");
		chk({15'h0000, regionBlocked}, 16'h0001, "write busy");
		cyc(PCYC + 4);
		wr(8'h11);
		core.spm(0, 16'h0000, 16'h0000);
		cyc(2);
		chk({15'h0000, regionBlocked}, 16'h0000, "reopen");
		$display("test region done");

		wr(8'h03);
		core.spm(0, 16'h0000, 16'h7000);
		n = 0;
		for (int i = 0; i < 200; i++)
		begin
			cyc(1);
			if (cpuHalt === 1'b1)
				n++;
			else if (n > 0)
				break;
		end
		if (cpuHalt === 1'b1)
		begin
			$display("mismatch at %0t: halt stuck", $time);
			errCount++;
			complete_run();
		end
		chk({15'h0000, n >= PCYC && n <= PCYC + 1}, 16'h0001, "halt length");
		chk({15'h0000, regionBlocked}, 16'h0000, "stall region");
		cyc(4);
		$display("test stall done");

		foreach (lockR0[i])
		begin
			wr(8'h09);
			core.spm(0, {8'hA5, lockR0[i]}, 16'h1234);
			cyc(PCYC + 4);
			chk({8'h00, lockByte}, {8'h00, lockExp[i]}, "lock byte");
			chk({12'h000, progLocked, fuseLocked, verifyLocked, bootLockLocked}, {12'h000, modeExp[i]}, "mode");
			wr(8'h09);
			lp(16'h0000, lockExp[i]);
			wr(8'h09);
			lp(16'h0001, fuseByte);
			rd(1'b0, SPFC_CSR_DATA_ADDR, 8'h00);
		end
		@(posedge clock);
		chipErase <= 1'b1;
		@(posedge clock);
		chipErase <= 1'b0;
		cyc(3);
		chk({4'h0, progLocked, fuseLocked, verifyLocked, bootLockLocked, lockByte}, 16'h00FF, "chip erase");
		$display("test lock done");

		wr(8'h21);
		lp(16'h0000, signatureByte);
		wr(8'h21);
		core.spm(0, ~w, {10'h000, idx, 1'b0});
		cyc(6);
		chk(16'(nErase + nWrite), 16'h0003, "signature store");
		chk(bufRdData, w, "signature store buffer");
		rd(1'b0, SPFC_CSR_DATA_ADDR, 8'h00);
		$display("test signature done");

		@(posedge clock);
		globalIrqEnable <= 1'b1;
		core.csr(1'b1, 1'b1, SPFC_CSR_IO_ADDR, 8'h80);
		cyc(3);
		chk({15'h0000, irqReq}, 16'h0001, "irq idle");
		rd(1'b1, SPFC_CSR_IO_ADDR, 8'h80);
		wr(8'h83);
		core.spm(0, 16'h0000, 16'h0000);
		cyc(2);
		chk({15'h0000, irqReq}, 16'h0000, "irq busy");
		cyc(PCYC + 4);
		chk({15'h0000, irqReq}, 16'h0001, "irq done");
		@(posedge clock);
		globalIrqEnable <= 1'b0;
		cyc(3);
		chk({15'h0000, irqReq}, 16'h0000, "irq global off");
		$display("test irq done");
		complete_run();
	end
endmodule : spfc_flash_control_tb_top
